// ==== core/frch_consts.vh ====
// Constants of the fieldbus remote command handler.
`ifndef FRCH_CONSTS_VH
`define FRCH_CONSTS_VH
`define FRCH_REG_REMOTE 16'h0192
`define FRCH_REG_SETCUR 16'h01F5
`define FRCH_REG_STATUS 16'h01F9
`define FRCH_REG_ACTV 16'h01FB
`define FRCH_REG_ACTI 16'h01FC
`define FRCH_REG_ACTP 16'h01FD
`define FRCH_SLOT_REMOTE 4'h2
`define FRCH_IDX_REMOTE 8'h01
`define FRCH_SLOT_SETCUR 4'h2
`define FRCH_IDX_SETCUR 8'h18
`define FRCH_SLOT_ACTV 4'h2
`define FRCH_IDX_ACTV 8'h1C
`define FRCH_SLOT_ACTI 4'h2
`define FRCH_IDX_ACTI 8'h1D
`define FRCH_SLOT_ACTP 4'h2
`define FRCH_IDX_ACTP 8'h1E
`define FRCH_SLOT_STATUS 4'h1
`define FRCH_IDX_STATUS 8'h01
`define FRCH_SLOT_MIN 4'h1
`define FRCH_SLOT_MAX 4'h8
`define FRCH_PN_SLOT_MUL 16'h00FF
`define FRCH_PN_BASE 16'h0001
`define FRCH_REMOTE_ON 16'hFF00
`define FRCH_REMOTE_OFF 16'h0000
`define FRCH_SET_FULL 16'hCCCC
`define FRCH_SET_RESET 16'h0000
`define FRCH_ST_OK 2'h0
`define FRCH_ST_BADADDR 2'h1
`define FRCH_ST_DENIED 2'h2
`define FRCH_ST_RANGE 2'h3
`endif

// ==== core/frch_handler.v ====
// Fieldbus slave command handler: cyclic process image and acyclic slot/index access.
`include "frch_consts.vh"
module frch_handler #(
    parameter DATA_W = 16
) (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Cyclic process image, refreshed every bus cycle.
    input wire cycleStrobe,
    output reg [31:0] cycSlot1,
    output reg [DATA_W-1:0] cycSlot2,
    output reg [DATA_W-1:0] cycSlot3,
    output reg [DATA_W-1:0] cycSlot4,
    output reg cycValid,
    // Acyclic request from the bus layer.
    input wire reqValid,
    input wire reqWrite,
    input wire reqProfinet,
    input wire [3:0] reqSlot,
    input wire [15:0] reqIndex,
    input wire [DATA_W-1:0] reqData,
    // Acyclic answer to the bus layer.
    output reg ackValid,
    output reg ackError,
    output reg [1:0] ackStatus,
    output reg [DATA_W-1:0] ackData,
    // Unit side.
    input wire [31:0] unitStatus,
    input wire [DATA_W-1:0] actVoltage,
    input wire [DATA_W-1:0] actCurrent,
    input wire [DATA_W-1:0] actPower,
    input wire remoteAllowed,
    input wire unitBusy,
    output reg remoteActive,
    output reg [DATA_W-1:0] currentLimit,
    output reg [DATA_W-1:0] displaySetCurrent,
    output reg limitUpdate
);

    reg [15:0] localIndex;
    reg [15:0] pnBase;
    reg [2:0] target;
    reg slotOk;
    reg held;
    reg heldWrite;
    reg heldProfinet;
    reg [3:0] heldSlot;
    reg [15:0] heldIndex;
    reg [DATA_W-1:0] heldData;
    reg [DATA_W-1:0] setCurrent;
    reg busy;
    reg [DATA_W-1:0] next_ackData;
    reg [1:0] next_status;
    reg curWrite;
    reg curProfinet;
    reg [3:0] curSlot;
    reg [15:0] curIndex;
    reg [DATA_W-1:0] curData;
    wire hitRemote;
    wire hitSetCur;
    wire hitStatus;
    wire hitActV;
    wire hitActI;
    wire hitActP;

    localparam [2:0] T_NONE = 3'd0;
    localparam [2:0] T_REMOTE = 3'd1;
    localparam [2:0] T_SETCUR = 3'd2;
    localparam [2:0] T_STATUS = 3'd3;
    localparam [2:0] T_ACTV = 3'd4;
    localparam [2:0] T_ACTI = 3'd5;
    localparam [2:0] T_ACTP = 3'd6;

    // A request that arrives while the unit is busy is held until it can answer.
    wire curValid = held | reqValid;

    always @* begin
        if (held) begin
            curWrite = heldWrite;
            curProfinet = heldProfinet;
            curSlot = heldSlot;
            curIndex = heldIndex;
            curData = heldData;
        end else begin
            curWrite = reqWrite;
            curProfinet = reqProfinet;
            curSlot = reqSlot;
            curIndex = reqIndex;
            curData = reqData;
        end
    end

    // Index decode per variant, then the slot/index table.
    always @* begin
        pnBase = 16'h0000;
        localIndex = 16'h0000;
        slotOk = (curSlot >= `FRCH_SLOT_MIN) && (curSlot <= `FRCH_SLOT_MAX);
        if (curProfinet) begin
            pnBase = {12'h000, curSlot} * `FRCH_PN_SLOT_MUL + `FRCH_PN_BASE;
            localIndex = curIndex - pnBase;
            if (curIndex < pnBase) begin
                slotOk = 1'b0;
            end
        end else begin
            localIndex = curIndex;
        end
    end

    // Table entries, one per register reachable over acyclic access.
    frch_slot_match #(
        .SLOT(`FRCH_SLOT_REMOTE),
        .INDEX(`FRCH_IDX_REMOTE)
    ) i_frch_slot_match_remote (
        .slot(curSlot),
        .localIndex(localIndex),
        .addrOk(slotOk),
        .hit(hitRemote)
    );

    frch_slot_match #(
        .SLOT(`FRCH_SLOT_SETCUR),
        .INDEX(`FRCH_IDX_SETCUR)
    ) i_frch_slot_match_setcur (
        .slot(curSlot),
        .localIndex(localIndex),
        .addrOk(slotOk),
        .hit(hitSetCur)
    );

    frch_slot_match #(
        .SLOT(`FRCH_SLOT_STATUS),
        .INDEX(`FRCH_IDX_STATUS)
    ) i_frch_slot_match_status (
        .slot(curSlot),
        .localIndex(localIndex),
        .addrOk(slotOk),
        .hit(hitStatus)
    );

    frch_slot_match #(
        .SLOT(`FRCH_SLOT_ACTV),
        .INDEX(`FRCH_IDX_ACTV)
    ) i_frch_slot_match_actv (
        .slot(curSlot),
        .localIndex(localIndex),
        .addrOk(slotOk),
        .hit(hitActV)
    );

    frch_slot_match #(
        .SLOT(`FRCH_SLOT_ACTI),
        .INDEX(`FRCH_IDX_ACTI)
    ) i_frch_slot_match_acti (
        .slot(curSlot),
        .localIndex(localIndex),
        .addrOk(slotOk),
        .hit(hitActI)
    );

    frch_slot_match #(
        .SLOT(`FRCH_SLOT_ACTP),
        .INDEX(`FRCH_IDX_ACTP)
    ) i_frch_slot_match_actp (
        .slot(curSlot),
        .localIndex(localIndex),
        .addrOk(slotOk),
        .hit(hitActP)
    );

    // Slot/index table; the first entry that matches wins.
    always @* begin
        target = T_NONE;
        if (hitRemote) begin
            target = T_REMOTE;
        end else if (hitSetCur) begin
            target = T_SETCUR;
        end else if (hitStatus) begin
            target = T_STATUS;
        end else if (hitActV) begin
            target = T_ACTV;
        end else if (hitActI) begin
            target = T_ACTI;
        end else if (hitActP) begin
            target = T_ACTP;
        end
    end

    // Answer data and status; read status never depends on remote state, only the remote register's read data does.
    always @* begin
        next_ackData = {DATA_W{1'b0}};
        next_status = `FRCH_ST_OK;
        case (target)
            T_REMOTE: next_ackData = remoteActive ? `FRCH_REMOTE_ON : `FRCH_REMOTE_OFF;
            T_SETCUR: next_ackData = setCurrent;
            T_STATUS: next_ackData = unitStatus[DATA_W-1:0];
            T_ACTV: next_ackData = actVoltage;
            T_ACTI: next_ackData = actCurrent;
            T_ACTP: next_ackData = actPower;
            default: next_status = `FRCH_ST_BADADDR;
        endcase
        if (curWrite && next_status == `FRCH_ST_OK) begin
            next_ackData = {DATA_W{1'b0}};
            case (target)
                T_REMOTE: begin
                    if (curData != `FRCH_REMOTE_ON && curData != `FRCH_REMOTE_OFF) begin
                        next_status = `FRCH_ST_RANGE;
                    end else if (curData == `FRCH_REMOTE_ON && !remoteAllowed) begin
                        next_status = `FRCH_ST_DENIED;
                    end
                end
                T_SETCUR: begin
                    if (!remoteActive) begin
                        next_status = `FRCH_ST_DENIED;
                    end else if (curData > `FRCH_SET_FULL) begin
                        next_status = `FRCH_ST_RANGE;
                    end
                end
                default: next_status = `FRCH_ST_DENIED;
            endcase
        end
    end

    always @* begin
        busy = unitBusy;
    end

    always @(posedge clk) begin
        if (reset) begin
            cycSlot1 <= 32'h0000_0000;
            cycSlot2 <= {DATA_W{1'b0}};
            cycSlot3 <= {DATA_W{1'b0}};
            cycSlot4 <= {DATA_W{1'b0}};
            cycValid <= 1'b0;
        end else begin
            cycValid <= cycleStrobe;
            if (cycleStrobe) begin
                // Slots 5 to 8 have no cyclic data at all.
                cycSlot1 <= unitStatus;
                cycSlot2 <= actVoltage;
                cycSlot3 <= actCurrent;
                cycSlot4 <= actPower;
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            held <= 1'b0;
            heldWrite <= 1'b0;
            heldProfinet <= 1'b0;
            heldSlot <= 4'h0;
            heldIndex <= 16'h0000;
            heldData <= {DATA_W{1'b0}};
            ackValid <= 1'b0;
            ackError <= 1'b0;
            ackStatus <= `FRCH_ST_OK;
            ackData <= {DATA_W{1'b0}};
            remoteActive <= 1'b0;
        end else begin
            ackValid <= 1'b0;
            if (curValid && busy) begin
                held <= 1'b1;
                if (!held) begin
                    heldWrite <= reqWrite;
                    heldProfinet <= reqProfinet;
                    heldSlot <= reqSlot;
                    heldIndex <= reqIndex;
                    heldData <= reqData;
                end
            end else if (curValid) begin
                held <= 1'b0;
                ackValid <= 1'b1;
                ackStatus <= next_status;
                ackError <= (next_status != `FRCH_ST_OK);
                ackData <= next_ackData;
                if (curWrite && next_status == `FRCH_ST_OK) begin
                    if (target == T_REMOTE) begin
                        remoteActive <= (curData == `FRCH_REMOTE_ON);
                    end
                end
            end
        end
    end

    // Setpoint store; it changes only on an accepted setpoint write.
    always @(posedge clk) begin
        if (reset) begin
            setCurrent <= `FRCH_SET_RESET;
            currentLimit <= `FRCH_SET_RESET;
            displaySetCurrent <= `FRCH_SET_RESET;
            limitUpdate <= 1'b0;
        end else begin
            limitUpdate <= 1'b0;
            if (curValid && !busy && curWrite && next_status == `FRCH_ST_OK
                    && target == T_SETCUR) begin
                setCurrent <= curData;
                currentLimit <= curData;
                displaySetCurrent <= curData;
                limitUpdate <= 1'b1;
            end
        end
    end

endmodule

// One entry of the slot/index table: true when the decoded address selects it.
module frch_slot_match #(
    parameter [3:0] SLOT = 4'h0,
    parameter [7:0] INDEX = 8'h00
) (
    // Decoded address.
    input wire [3:0] slot,
    input wire [15:0] localIndex,
    input wire addrOk,
    // Table hit.
    output wire hit
);
    assign hit = addrOk && (slot == SLOT) && (localIndex == {8'h00, INDEX});
endmodule

// ==== dv/frch_master_model.sv ====
// Fieldbus master model issuing acyclic requests.
module frch_master_model (
    // Clock.
    input logic clk,
    // Request.
    output logic reqValid,
    output logic reqWrite,
    output logic reqProfinet,
    output logic [3:0] reqSlot,
    output logic [15:0] reqIndex,
    output logic [15:0] reqData,
    // Answer.
    input logic ackValid,
    input logic [1:0] ackStatus,
    input logic [15:0] ackData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reqValid, reqWrite, reqProfinet, reqSlot, reqIndex, reqData} = '0;
    task automatic access(input logic w, pn, input logic [3:0] s, input logic [7:0] i,
            input logic [15:0] d, output logic [1:0] st, output logic [15:0] q);
        int n = 0;
        @(posedge clk);
        {reqValid, reqWrite, reqProfinet, reqSlot, reqData} <= {1'b1, w, pn, s, d};
        reqIndex <= pn ? s * 16'h00FF + 16'h0001 + i : {8'h00, i};
        @(posedge clk);
        reqValid <= 1'b0;
        do @(negedge clk); while (ackValid !== 1'b1 && ++n < 20);
        st = ackStatus;
        q = ackData;
    endtask
endmodule

// ==== dv/frch_handler_props.sv ====
// Checker on the handler ports.
module frch_handler_props (
    // Clock and reset.
    input logic clk,
    input logic reset,
    // Bus side.
    input logic cycleStrobe,
    input logic cycValid,
    input logic reqValid,
    input logic ackValid,
    // Unit side.
    input logic remoteAllowed,
    input logic unitBusy,
    input logic remoteActive,
    input logic [15:0] currentLimit,
    input logic [15:0] displaySetCurrent,
    input logic limitUpdate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_cyc_refresh: assert property (cycleStrobe |=> cycValid)
        else $error("cyclic refresh missed");
    a_ack_prompt: assert property (reqValid && !unitBusy |=> ackValid)
        else $error("answer late");
    a_remote_entry: assert property (
        $rose(remoteActive) |-> $past(reqValid && remoteAllowed))
        else $error("remote entered without grant");
    a_set_gated: assert property (limitUpdate |-> $past(remoteActive))
        else $error("setpoint taken while manual");
    a_set_range: assert property (limitUpdate |-> currentLimit <= 16'hCCCC)
        else $error("setpoint over full scale");
    a_set_display: assert property (limitUpdate |-> displaySetCurrent == currentLimit)
        else $error("display differs from limit");
    a_set_answer: assert property (limitUpdate |-> ackValid)
        else $error("limit not updated with answer");
    a_set_kept: assert property (!limitUpdate |-> $stable(currentLimit))
        else $error("limit changed without update");
    c_setpoint: cover property (limitUpdate);
    c_remote_on: cover property ($rose(remoteActive));
    c_cyclic: cover property (cycValid);
endmodule
bind frch_handler frch_handler_props i_frch_handler_props (.clk, .reset, .cycleStrobe,
    .cycValid, .reqValid, .ackValid, .remoteAllowed, .unitBusy, .remoteActive, .currentLimit,
    .displaySetCurrent, .limitUpdate);

// ==== dv/tb_frch_handler.sv ====
// Self-checking testbench of the fieldbus remote command handler.
module tb_frch_handler;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, a) begin testsRun++; if ((a) !== (e)) begin nFail++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cycleStrobe, reqValid, reqWrite, reqProfinet, remoteAllowed, unitBusy;
    logic cycValid, ackValid, ackError, remoteActive, limitUpdate;
    logic [1:0] ackStatus, st;
    logic [3:0] reqSlot;
    logic [15:0] reqIndex, reqData, actVoltage, actCurrent, actPower, ackData, q;
    logic [15:0] cycSlot2, cycSlot3, cycSlot4, currentLimit, displaySetCurrent;
    logic [31:0] cycSlot1, unitStatus;
    int nFail = 0;
    int testsRun = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    frch_handler i_frch_handler (.clk, .reset, .cycleStrobe, .cycSlot1, .cycSlot2, .cycSlot3,
        .cycSlot4, .cycValid, .reqValid, .reqWrite, .reqProfinet, .reqSlot, .reqIndex, .reqData,
        .ackValid, .ackError, .ackStatus, .ackData, .unitStatus, .actVoltage, .actCurrent,
        .actPower, .remoteAllowed, .unitBusy, .remoteActive, .currentLimit, .displaySetCurrent,
        .limitUpdate);
    frch_master_model i_frch_master_model (.clk, .reqValid, .reqWrite, .reqProfinet, .reqSlot,
        .reqIndex, .reqData, .ackValid, .ackStatus, .ackData);
    task automatic acc(input logic w, pn, input logic [3:0] s, input logic [7:0] i,
            input logic [15:0] d, input logic [1:0] es, input logic [15:0] eq);
        i_frch_master_model.access(w, pn, s, i, d, st, q);
        `CHK("ackValid", 1'b1, ackValid)
        `CHK("ackError", es != 2'h0, ackError)
        `CHK("ackStatus", es, st)
        `CHK("ackData", eq, q)
    endtask
    task automatic t_cyclic();
        @(posedge clk) cycleStrobe <= 1'b1;
        @(posedge clk) cycleStrobe <= 1'b0;
        @(negedge clk) `CHK("cycValid", 1'b1, cycValid)
        `CHK("cycSlot1", 32'h0000_04C0, cycSlot1)
        `CHK("cycSlot2", 16'h263A, cycSlot2)
        `CHK("cycSlot3", 16'h0C9B, cycSlot3)
        `CHK("cycSlot4", 16'h0925, cycSlot4)
        @(negedge clk) `CHK("cycValid", 1'b0, cycValid)
    endtask
    task automatic t_query();
        acc(0, 0, 2, 28, 0, 0, 16'h263A);
        acc(0, 1, 2, 29, 0, 0, 16'h0C9B);
        acc(0, 0, 9, 1, 0, 1, 0);
        acc(0, 0, 5, 1, 0, 1, 0);
    endtask
    task automatic t_busy();
        @(posedge clk) unitBusy <= 1'b1;
        fork
            acc(0, 0, 2, 30, 0, 0, 16'h0925);
            begin
                repeat (3) @(posedge clk);
                @(negedge clk) `CHK("ackValid", 1'b0, ackValid)
                @(posedge clk) unitBusy <= 1'b0;
            end
        join
    endtask
    task automatic t_remote();
        acc(1, 0, 2, 1, 16'hFF00, 2, 0);
        `CHK("remoteActive", 1'b0, remoteActive)
        @(posedge clk) remoteAllowed <= 1'b1;
        acc(1, 0, 2, 24, 16'h0C0C, 2, 0);
        acc(1, 0, 2, 1, 16'h1234, 3, 0);
        acc(1, 0, 2, 1, 16'hFF00, 0, 0);
        `CHK("remoteActive", 1'b1, remoteActive)
        acc(1, 1, 2, 24, 16'h0C0C, 0, 0);
        `CHK("displaySetCurrent", 16'h0C0C, displaySetCurrent)
        `CHK("currentLimit", 16'h0C0C, currentLimit)
        acc(1, 0, 2, 24, 16'hCCCD, 3, 0);
        acc(0, 0, 2, 24, 0, 0, 16'h0C0C);
        acc(1, 0, 2, 1, 16'h0000, 0, 0);
        `CHK("remoteActive", 1'b0, remoteActive)
        acc(1, 0, 2, 24, 16'h0001, 2, 0);
        `CHK("currentLimit", 16'h0C0C, currentLimit)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) if (++cycles == 3000) begin
        nFail++;
        summarize();
    end
    initial begin
        {cycleStrobe, remoteAllowed, unitBusy} = 3'b000;
        {unitStatus, actVoltage} = {32'h0000_04C0, 16'h263A};
        {actCurrent, actPower} = {16'h0C9B, 16'h0925};
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_cyclic();
        t_query();
        t_busy();
        t_remote();
        summarize();
    end
endmodule
